// File: rtl/avg_pkg.sv
// shared constants, types and helpers of the amplifier volume, pwm and gain register block
package avg_pkg;

   typedef logic [7:0] avg_byte_t;

   // register byte offsets on the control bus
   localparam avg_byte_t AVG_OFS_SLOT_CTRL = 8'h03;
   localparam avg_byte_t AVG_OFS_VOLUME = 8'h04;
   localparam avg_byte_t AVG_OFS_ANALOG = 8'h06;
   localparam avg_byte_t AVG_UNMAPPED_RD = 8'h00;

   // reset values; reserved bit 7 of slot control comes up set
   localparam avg_byte_t AVG_RST_SLOT_CTRL = 8'h80;
   localparam avg_byte_t AVG_RST_VOLUME = 8'hCF;
   // pwm rate 101, analog gain 01, reserved low pair 01
   localparam avg_byte_t AVG_RST_ANALOG = 8'h55;

   // field positions
   localparam int AVG_RAMP_RATE_BIT = 6;
   localparam int AVG_MUTE_BIT = 4;
   localparam int AVG_SLOT_LSB = 0;
   localparam int AVG_SLOT_W = 3;
   localparam int AVG_PWM_LSB = 4;
   localparam int AVG_PWM_W = 3;
   localparam int AVG_GAIN_LSB = 2;
   localparam int AVG_GAIN_W = 2;

   // volume level, 9 bits, quarter-decibel steps
   localparam int AVG_VOL_W = 9;
   localparam logic [AVG_VOL_W-1:0] AVG_MUTE_LEVEL = 9'h008;
   localparam logic [AVG_VOL_W-1:0] AVG_LEVEL_ZERO = 9'h000;
   localparam logic [AVG_VOL_W-1:0] AVG_LEVEL_STEP = 9'h001;

   // frame periods per ramp step: last count of the step divider
   localparam int AVG_FRAME_CNT_W = 3;
   localparam logic [AVG_FRAME_CNT_W-1:0] AVG_SLOW_LAST = 3'h7;
   localparam logic [AVG_FRAME_CNT_W-1:0] AVG_FAST_LAST = 3'h0;
   localparam logic [AVG_FRAME_CNT_W-1:0] AVG_FRAME_ONE = 3'h1;

   // pwm multiple of the frame clock
   localparam int AVG_PWM_MULT_W = 5;

   // two-wire bus byte handling
   localparam logic [3:0] AVG_BYTE_BITS = 4'h8;
   localparam logic [3:0] AVG_BIT_ONE = 4'h1;
   localparam logic [3:0] AVG_BIT_ZERO = 4'h0;

   typedef enum logic [3:0] {
      AVG_ST_IDLE, AVG_ST_ADDR, AVG_ST_ACK_ADDR, AVG_ST_PTR, AVG_ST_ACK_PTR,
      AVG_ST_WDATA, AVG_ST_ACK_W, AVG_ST_RDATA, AVG_ST_RACK
   } avg_i2c_state_e;

   // switching multiple from the rate code; double speed halves it
   function automatic logic [AVG_PWM_MULT_W-1:0] avg_pwm_multiple(input logic [AVG_PWM_W-1:0] code,
                                                                  input logic dbl);
      logic [AVG_PWM_MULT_W-1:0] m;
      m = 5'h10;
      unique case (code)
         3'h0: m = 5'h06;
         3'h1: m = 5'h08;
         3'h2: m = 5'h0A;
         3'h3: m = 5'h0C;
         3'h4: m = 5'h0E;
         3'h5: m = 5'h10;
         3'h6: m = 5'h14;
         3'h7: m = 5'h18;
      endcase
      return dbl ? (m >> 1) : m;
   endfunction

endpackage

// File: rtl/avg_ramp_if.sv
// interface between the register block and its volume ramp engine
`timescale 1ns/10ps
`default_nettype none
interface avg_ramp_if;
   logic [avg_pkg::AVG_VOL_W-1:0] target;
   logic step_fast;
   logic frame_tick;
   logic [avg_pkg::AVG_VOL_W-1:0] level;
   logic idle;
   logic busy;

   modport ctrl(output target, output step_fast, output frame_tick, input level, input idle, input busy);
   modport ramp(input target, input step_fast, input frame_tick, output level, output idle, output busy);
endinterface
`default_nettype wire

// File: rtl/avg_pin_sync.sv
// two-flop synchroniser for pins from outside the system clock domain
`timescale 1ns/10ps
`default_nettype none
module avg_pin_sync #(
   parameter int WIDTH = 1,
   parameter logic [WIDTH-1:0] RST_VAL = '0
) (
   input wire logic clk_sys_i,
   input wire logic sys_rst_i,
   input wire logic [WIDTH-1:0] async_i,
   output logic [WIDTH-1:0] sync_o
);
   logic [WIDTH-1:0] meta_q;
   logic [WIDTH-1:0] sync_q;

   // meta stage feeds only the second stage
   always_ff @(posedge clk_sys_i) begin
      if (sys_rst_i) begin
         meta_q <= RST_VAL;
         sync_q <= RST_VAL;
      end else begin
         meta_q <= async_i;
         sync_q <= meta_q;
      end
   end

   assign sync_o = sync_q;
endmodule
`default_nettype wire

// File: rtl/avg_vol_ramp.sv
// volume ramp engine stepping the live level toward its target on frame ticks
`timescale 1ns/10ps
`default_nettype none
module avg_vol_ramp (
   input wire logic clk_sys_i,
   input wire logic sys_rst_i,
   avg_ramp_if.ramp rif
);
   import avg_pkg::*;

   logic [AVG_FRAME_CNT_W-1:0] frame_cnt_q;
   logic [AVG_VOL_W-1:0] level_q;
   logic [AVG_FRAME_CNT_W-1:0] last_cnt;
   logic step_due;

   assign last_cnt = rif.step_fast ? AVG_FAST_LAST : AVG_SLOW_LAST;
   assign step_due = rif.frame_tick && (frame_cnt_q >= last_cnt);

   // frame divider; >= keeps it sane when the rate bit flips mid-count
   always_ff @(posedge clk_sys_i) begin
      if (sys_rst_i) begin
         frame_cnt_q <= AVG_FAST_LAST;
      end else if (step_due) begin
         frame_cnt_q <= AVG_FAST_LAST;
      end else if (rif.frame_tick) begin
         frame_cnt_q <= frame_cnt_q + AVG_FRAME_ONE;
      end
   end

   always_ff @(posedge clk_sys_i) begin
      if (sys_rst_i) begin
         level_q <= AVG_RST_VOLUME[7:0] == 8'h00 ? AVG_LEVEL_ZERO : {AVG_RST_VOLUME, 1'b0};
      end else if (step_due) begin
         if (level_q < rif.target) begin
            level_q <= level_q + AVG_LEVEL_STEP;
         end else if (level_q > rif.target) begin
            level_q <= level_q - AVG_LEVEL_STEP;
         end
      end
   end

   assign rif.level = level_q;
   assign rif.idle = level_q < AVG_MUTE_LEVEL;
   assign rif.busy = level_q != rif.target;
endmodule
`default_nettype wire

// File: rtl/avg_regs_top.sv
// volume, mute, slot, pwm rate and analog gain registers behind the two-wire control bus
`timescale 1ns/10ps
`default_nettype none
// Overview of operation
// - entering or leaving mute ramps 0.25 dB per 8 frames, or per frame when fast
// - mute bit ramps volume down to idle audio; clearing it ramps back up
// - slot-select field bits 2..0 picks the playback TDM channel when source bit set
// - volume is nine bits: register gives upper eight, external bit gives the LSB
// - volume spans -100 to +24 dB in quarter steps, resets to 0xCF for 0 dB
// - any nine-bit volume below 0x008 behaves exactly like mute
// - pwm rate code sets frame clock multiple 6..24, halved in double speed
// - two-bit analog gain field selects full-scale output level
// - analog gain reset value is taken as 01, the printed reset column
// - slot source 0 uses the bus device identifier, 1 uses slot-select field
// - speed bit picks single or double speed, choosing which pwm multiple applies
module avg_regs_top #(
   parameter logic [3:0] ADDR_HI = 4'h5
) (
   input wire logic clk_sys_i,
   input wire logic sys_rst_i,
   input wire logic scl_i,
   input wire logic sda_i,
   output logic sda_o,
   output logic sda_oe_o,
   input wire logic lrclk_i,
   input wire logic [2:0] dev_id_i,
   input wire logic channel_source_sel_i,
   input wire logic speed_select_i,
   input wire logic volume_lsb_i,
   input wire logic shutdown_req_i,
   input wire logic sleep_req_i,
   output logic [avg_pkg::AVG_VOL_W-1:0] level_o,
   output logic audio_idle_o,
   output logic ramp_busy_o,
   output logic [avg_pkg::AVG_SLOT_W-1:0] playback_slot_o,
   output logic [avg_pkg::AVG_PWM_MULT_W-1:0] pwm_multiple_o,
   output logic [avg_pkg::AVG_GAIN_W-1:0] analog_gain_o
);
   import avg_pkg::*;

   // synchronised pins and their previous samples
   logic scl_s;
   logic sda_s;
   logic lrclk_s;
   logic [2:0] dev_id_s;
   logic scl_p_q;
   logic sda_p_q;
   logic lrclk_p_q;
   logic start_det;
   logic stop_det;
   logic scl_rise;
   logic scl_fall;

   // bus engine state
   avg_i2c_state_e state_q;
   logic [3:0] bit_cnt_q;
   avg_byte_t shift_q;
   avg_byte_t tx_q;
   avg_byte_t ptr_q;
   logic rw_q;
   logic drive_q;
   logic wr_stb_q;
   avg_byte_t wr_data_q;
   logic [6:0] own_addr;
   avg_byte_t rd_cur;

   // register storage
   avg_byte_t slot_ctrl_q;
   avg_byte_t volume_q;
   avg_byte_t analog_q;

   // derived volume and output flops
   logic [AVG_VOL_W-1:0] vol_setting;
   logic mute_req;
   logic [AVG_SLOT_W-1:0] slot_q;
   logic [AVG_PWM_MULT_W-1:0] pwm_mult_q;
   logic [AVG_GAIN_W-1:0] gain_q;
   logic idle_q;
   logic busy_q;

   avg_ramp_if rif ();

   // read mux; unmapped offsets answer with zero
   function automatic avg_byte_t rd_byte(input avg_byte_t ofs, input avg_byte_t slot_r,
                                         input avg_byte_t vol_r, input avg_byte_t ana_r);
      avg_byte_t d;
      d = AVG_UNMAPPED_RD;
      if (ofs == AVG_OFS_SLOT_CTRL) begin
         d = slot_r;
      end else if (ofs == AVG_OFS_VOLUME) begin
         d = vol_r;
      end else if (ofs == AVG_OFS_ANALOG) begin
         d = ana_r;
      end
      return d;
   endfunction

   // pin synchronisers; bus lines idle high
   avg_pin_sync #(.WIDTH(2), .RST_VAL(2'h3)) u_sync_bus (
      .clk_sys_i(clk_sys_i),
      .sys_rst_i(sys_rst_i),
      .async_i({scl_i, sda_i}),
      .sync_o({scl_s, sda_s})
   );

   avg_pin_sync #(.WIDTH(4), .RST_VAL(4'h0)) u_sync_misc (
      .clk_sys_i(clk_sys_i),
      .sys_rst_i(sys_rst_i),
      .async_i({lrclk_i, dev_id_i}),
      .sync_o({lrclk_s, dev_id_s})
   );

   // edge history, taken from the settled second stage only
   always_ff @(posedge clk_sys_i) begin
      if (sys_rst_i) begin
         scl_p_q <= 1'b1;
         sda_p_q <= 1'b1;
         lrclk_p_q <= 1'b0;
      end else begin
         scl_p_q <= scl_s;
         sda_p_q <= sda_s;
         lrclk_p_q <= lrclk_s;
      end
   end

   // bus conditions: start and stop are sda edges while scl is high
   assign start_det = scl_s && scl_p_q && sda_p_q && !sda_s;
   assign stop_det = scl_s && scl_p_q && !sda_p_q && sda_s;
   assign scl_rise = scl_s && !scl_p_q;
   assign scl_fall = !scl_s && scl_p_q;

   // identifier also forms the low address bits
   assign own_addr = {ADDR_HI, dev_id_s};
   assign rd_cur = rd_byte(ptr_q, slot_ctrl_q, volume_q, analog_q);

   // bus engine: sample on scl rise, change sda after scl fall
   always_ff @(posedge clk_sys_i) begin
      if (sys_rst_i) begin
         state_q <= AVG_ST_IDLE;
         bit_cnt_q <= AVG_BIT_ZERO;
         shift_q <= 8'h00;
         tx_q <= 8'h00;
         ptr_q <= 8'h00;
         rw_q <= 1'b0;
         drive_q <= 1'b0;
         wr_stb_q <= 1'b0;
         wr_data_q <= 8'h00;
      end else begin
         wr_stb_q <= 1'b0;
         if (start_det) begin
            // repeated start keeps the pointer for a combined read
            state_q <= AVG_ST_ADDR;
            bit_cnt_q <= AVG_BIT_ZERO;
            drive_q <= 1'b0;
         end else if (stop_det) begin
            state_q <= AVG_ST_IDLE;
            drive_q <= 1'b0;
         end else if (scl_rise) begin
            if (state_q == AVG_ST_ADDR || state_q == AVG_ST_PTR || state_q == AVG_ST_WDATA) begin
               shift_q <= {shift_q[6:0], sda_s};
               bit_cnt_q <= bit_cnt_q + AVG_BIT_ONE;
            end else if (state_q == AVG_ST_RACK && sda_s) begin
               // host declined more data
               state_q <= AVG_ST_IDLE;
            end
         end else if (scl_fall) begin
            unique case (state_q)
               AVG_ST_IDLE: begin
                  drive_q <= 1'b0;
               end
               AVG_ST_ADDR: begin
                  if (bit_cnt_q == AVG_BYTE_BITS) begin
                     if (shift_q[7:1] == own_addr) begin
                        rw_q <= shift_q[0];
                        drive_q <= 1'b1;
                        state_q <= AVG_ST_ACK_ADDR;
                     end else begin
                        state_q <= AVG_ST_IDLE;
                     end
                  end
               end
               AVG_ST_ACK_ADDR: begin
                  if (rw_q) begin
                     tx_q <= rd_cur;
                     drive_q <= !rd_cur[7];
                     bit_cnt_q <= AVG_BIT_ONE;
                     state_q <= AVG_ST_RDATA;
                  end else begin
                     drive_q <= 1'b0;
                     bit_cnt_q <= AVG_BIT_ZERO;
                     state_q <= AVG_ST_PTR;
                  end
               end
               AVG_ST_PTR: begin
                  if (bit_cnt_q == AVG_BYTE_BITS) begin
                     ptr_q <= shift_q;
                     drive_q <= 1'b1;
                     state_q <= AVG_ST_ACK_PTR;
                  end
               end
               AVG_ST_ACK_PTR: begin
                  drive_q <= 1'b0;
                  bit_cnt_q <= AVG_BIT_ZERO;
                  state_q <= AVG_ST_WDATA;
               end
               AVG_ST_WDATA: begin
                  if (bit_cnt_q == AVG_BYTE_BITS) begin
                     wr_stb_q <= 1'b1;
                     wr_data_q <= shift_q;
                     drive_q <= 1'b1;
                     state_q <= AVG_ST_ACK_W;
                  end
               end
               AVG_ST_ACK_W: begin
                  // auto-increment for burst writes
                  drive_q <= 1'b0;
                  bit_cnt_q <= AVG_BIT_ZERO;
                  ptr_q <= ptr_q + 8'h01;
                  state_q <= AVG_ST_WDATA;
               end
               AVG_ST_RDATA: begin
                  if (bit_cnt_q == AVG_BYTE_BITS) begin
                     drive_q <= 1'b0;
                     ptr_q <= ptr_q + 8'h01;
                     state_q <= AVG_ST_RACK;
                  end else begin
                     drive_q <= !tx_q[6];
                     tx_q <= {tx_q[6:0], 1'b0};
                     bit_cnt_q <= bit_cnt_q + AVG_BIT_ONE;
                  end
               end
               AVG_ST_RACK: begin
                  // host acked: pointer already moved on
                  tx_q <= rd_cur;
                  drive_q <= !rd_cur[7];
                  bit_cnt_q <= AVG_BIT_ONE;
                  state_q <= AVG_ST_RDATA;
               end
            endcase
         end
      end
   end

   // open drain: only ever pull low
   assign sda_o = 1'b0;
   assign sda_oe_o = drive_q;

   // register writes; whole bytes kept so reserved bits read back
   always_ff @(posedge clk_sys_i) begin
      if (sys_rst_i) begin
         slot_ctrl_q <= AVG_RST_SLOT_CTRL;
         volume_q <= AVG_RST_VOLUME;
         analog_q <= AVG_RST_ANALOG;
      end else if (wr_stb_q) begin
         if (ptr_q == AVG_OFS_SLOT_CTRL) begin
            slot_ctrl_q <= wr_data_q;
         end else if (ptr_q == AVG_OFS_VOLUME) begin
            volume_q <= wr_data_q;
         end else if (ptr_q == AVG_OFS_ANALOG) begin
            analog_q <= wr_data_q;
         end
      end
   end

   assign vol_setting = {volume_q, volume_lsb_i};

   assign mute_req = slot_ctrl_q[AVG_MUTE_BIT] || shutdown_req_i || sleep_req_i || (vol_setting < AVG_MUTE_LEVEL);

   // ramp engine drive
   assign rif.target = mute_req ? AVG_LEVEL_ZERO : vol_setting;
   assign rif.step_fast = slot_ctrl_q[AVG_RAMP_RATE_BIT];
   assign rif.frame_tick = lrclk_s && !lrclk_p_q;

   avg_vol_ramp u_ramp (
      .clk_sys_i(clk_sys_i),
      .sys_rst_i(sys_rst_i),
      .rif(rif)
   );

   // registered decoded outputs
   always_ff @(posedge clk_sys_i) begin
      if (sys_rst_i) begin
         slot_q <= '0;
         pwm_mult_q <= '0;
         gain_q <= '0;
         idle_q <= 1'b0;
         busy_q <= 1'b0;
      end else begin
         slot_q <= channel_source_sel_i ? slot_ctrl_q[AVG_SLOT_LSB +: AVG_SLOT_W] : dev_id_s;
         pwm_mult_q <= avg_pwm_multiple(analog_q[AVG_PWM_LSB +: AVG_PWM_W], speed_select_i);
         gain_q <= analog_q[AVG_GAIN_LSB +: AVG_GAIN_W];
         idle_q <= rif.idle;
         busy_q <= rif.busy;
      end
   end

   assign level_o = rif.level;
   assign audio_idle_o = idle_q;
   assign ramp_busy_o = busy_q;
   assign playback_slot_o = slot_q;
   assign pwm_multiple_o = pwm_mult_q;
   assign analog_gain_o = gain_q;
endmodule
`default_nettype wire

// File: bench/avg_regs_props.sv
// concurrent checks on the ports of the volume, pwm and gain register block
`timescale 1ns/10ps
`default_nettype none
module avg_regs_props (
   input wire logic clk_sys_i,
   input wire logic sys_rst_i,
   input wire logic scl_i,
   input wire logic sda_i,
   input wire logic sda_o,
   input wire logic sda_oe_o,
   input wire logic lrclk_i,
   input wire logic [2:0] dev_id_i,
   input wire logic channel_source_sel_i,
   input wire logic speed_select_i,
   input wire logic volume_lsb_i,
   input wire logic shutdown_req_i,
   input wire logic sleep_req_i,
   input wire logic [avg_pkg::AVG_VOL_W-1:0] level_o,
   input wire logic audio_idle_o,
   input wire logic ramp_busy_o,
   input wire logic [avg_pkg::AVG_SLOT_W-1:0] playback_slot_o,
   input wire logic [avg_pkg::AVG_PWM_MULT_W-1:0] pwm_multiple_o,
   input wire logic [avg_pkg::AVG_GAIN_W-1:0] analog_gain_o
);
   import avg_pkg::*;
   default clocking cb @(posedge clk_sys_i); endclocking
   default disable iff (sys_rst_i);
   logic [3:0] since_fr_q;
   // cycles since the last frame clock rise; saturates so slow frames never wrap
   always_ff @(posedge clk_sys_i) begin
      if (sys_rst_i) since_fr_q <= 4'hF;
      else if ($rose(lrclk_i)) since_fr_q <= 4'h0;
      else if (since_fr_q != 4'hF) since_fr_q <= since_fr_q + 4'h1;
   end
   sequence s_single; !speed_select_i [*3]; endsequence
   sequence s_double; speed_select_i [*3]; endsequence
   sequence s_forced; shutdown_req_i [*3] ##0 $changed(level_o); endsequence
   AST_RESET_LEVEL: assert property ($fell(sys_rst_i) |-> level_o == 9'h19E)
      else $error("level not at reset volume");
   AST_RESET_DECODE: assert property ($fell(sys_rst_i) |=> analog_gain_o == 2'h1)
      else $error("gain not 01 after reset");
   AST_STEP_ONE: assert property ($changed(level_o) && !$past(sys_rst_i) |->
      (level_o - $past(level_o) == 9'h001) || ($past(level_o) - level_o == 9'h001))
      else $error("level moved by more than one step");
   AST_STEP_ON_TICK: assert property ($changed(level_o) && !$past(sys_rst_i) |-> since_fr_q <= 4'h6)
      else $error("level moved away from a frame tick");
   AST_IDLE_BELOW: assert property (!$past(sys_rst_i) |->
      audio_idle_o == ($past(level_o) < 9'h008))
      else $error("idle audio flag wrong for level");
   AST_PWM_SINGLE: assert property (s_single |-> pwm_multiple_o >= 5'h06 && !pwm_multiple_o[0])
      else $error("single speed pwm multiple out of set");
   AST_PWM_DOUBLE: assert property (s_double |-> pwm_multiple_o >= 5'h03 && pwm_multiple_o <= 5'h0C)
      else $error("double speed pwm multiple out of set");
   AST_SLOT_FROM_ID: assert property ((!channel_source_sel_i && $stable(dev_id_i)) [*6] |->
      playback_slot_o == dev_id_i)
      else $error("slot does not follow device id");
   AST_FORCED_DOWN: assert property (s_forced |-> level_o < $past(level_o))
      else $error("level rose while forced down");
   AST_BUSY_MOVING: assert property ($changed(level_o) && !$past(sys_rst_i) |->
      $past(ramp_busy_o) || ramp_busy_o)
      else $error("level moved while ramp idle");
endmodule
bind avg_regs_top avg_regs_props avg_regs_props_i (.clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i),
   .scl_i(scl_i), .sda_i(sda_i), .sda_o(sda_o), .sda_oe_o(sda_oe_o), .lrclk_i(lrclk_i),
   .dev_id_i(dev_id_i), .channel_source_sel_i(channel_source_sel_i), .speed_select_i(speed_select_i),
   .volume_lsb_i(volume_lsb_i), .shutdown_req_i(shutdown_req_i), .sleep_req_i(sleep_req_i),
   .level_o(level_o), .audio_idle_o(audio_idle_o), .ramp_busy_o(ramp_busy_o),
   .playback_slot_o(playback_slot_o), .pwm_multiple_o(pwm_multiple_o), .analog_gain_o(analog_gain_o));
`default_nettype wire

// File: bench/avg_host_model.sv
// two-wire bus host that reaches the register block
`timescale 1ns/10ps
`default_nettype none
module avg_host_model (
   input wire logic clk_i,
   input wire logic sda_i,
   output var logic scl_o,
   output var logic sda_low_o
);
   // bus idles released; the pull-up gives the high level
   initial begin
      scl_o = 1'b1;
      sda_low_o = 1'b0;
   end
   task automatic wait_c(input int n);
      repeat (n) @(posedge clk_i);
   endtask
   // quarter bit of 8 clocks leaves the device time to drive after its sync delay
   task automatic bit_c(input logic b, output logic s);
      wait_c(8);
      sda_low_o <= !b;
      wait_c(8);
      scl_o <= 1'b1;
      wait_c(8);
      s = sda_i;
      wait_c(8);
      scl_o <= 1'b0;
   endtask
   // start and repeated start alike: release, clock high, then pull data low
   task automatic start_c();
      wait_c(8);
      sda_low_o <= 1'b0;
      wait_c(8);
      scl_o <= 1'b1;
      wait_c(8);
      sda_low_o <= 1'b1;
      wait_c(8);
      scl_o <= 1'b0;
   endtask
   task automatic stop_c();
      wait_c(8);
      sda_low_o <= 1'b1;
      wait_c(8);
      scl_o <= 1'b1;
      wait_c(8);
      sda_low_o <= 1'b0;
      wait_c(8);
   endtask
   // eight bits msb first, then the ninth bit; ack is the line level seen there
   task automatic byte_c(input logic [7:0] tx, input logic last, output logic [7:0] rx, output logic ack);
      for (int i = 7; i >= 0; i--) bit_c(tx[i], rx[i]);
      bit_c(last, ack);
   endtask
endmodule
`default_nettype wire

// File: bench/test_amp_volume_pwm_gain_regs.sv
// self-checking testbench of the volume, pwm and gain register block
`timescale 1ns/10ps
`default_nettype none
module test_amp_volume_pwm_gain_regs;
   import avg_pkg::*;
   localparam logic [3:0] ADDR_HI = 4'h5;
   localparam logic [2:0] DEV_ID = 3'h3;
   localparam int LR_PER = 16;
   // single speed multiples, five bits per code, code 0 lowest; packed so free simulators take it
   localparam logic [39:0] PWM_TAB = {5'h18, 5'h14, 5'h10, 5'h0E, 5'h0C, 5'h0A, 5'h08, 5'h06};
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic scl, host_low, sda_o, sda_oe, lrclk = 1'b0, src = 1'b0, speed = 1'b0;
   logic vlsb = 1'b0, shut = 1'b0, sleep = 1'b0, idle, busy;
   logic [3:0] lr_cnt = 4'h0;
   logic [8:0] level;
   logic [2:0] slot;
   logic [4:0] pwm;
   logic [1:0] gain;
   wire logic sda_line;
   int failures = 0;
   int n_compared = 0;
   int cycles = 0;
   // open-drain line with pull-up: low when either party pulls
   assign sda_line = !(host_low || sda_oe);
   avg_regs_top #(.ADDR_HI(ADDR_HI)) avg_regs_top_i (.clk_sys_i(clk), .sys_rst_i(rst), .scl_i(scl),
      .sda_i(sda_line), .sda_o(sda_o), .sda_oe_o(sda_oe), .lrclk_i(lrclk), .dev_id_i(DEV_ID),
      .channel_source_sel_i(src), .speed_select_i(speed), .volume_lsb_i(vlsb), .shutdown_req_i(shut),
      .sleep_req_i(sleep), .level_o(level), .audio_idle_o(idle), .ramp_busy_o(busy),
      .playback_slot_o(slot), .pwm_multiple_o(pwm), .analog_gain_o(gain));
   avg_host_model avg_host_model_i (.clk_i(clk), .sda_i(sda_line), .scl_o(scl), .sda_low_o(host_low));
   // 4 ns clock
   initial begin
      forever #2 clk = !clk;
   end
   // free-running frame clock of LR_PER cycles; cut a hung run short
   always @(posedge clk) begin
      lr_cnt <= lr_cnt + 4'h1;
      lrclk <= (lr_cnt >= 4'h8);
      cycles <= cycles + 1;
      if (cycles == 80000) begin
         failures++;
         end_sim();
      end
   end
   task automatic end_sim();
      $display("compared %0d, failures %0d", n_compared, failures);
      if (failures == 0 && n_compared > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
      n_compared++;
      if (g !== e) begin
         failures++;
         $display("BAD %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic wr(input avg_byte_t ofs, input avg_byte_t val);
      logic a0, a1, a2;
      avg_byte_t rx;
      avg_host_model_i.start_c();
      avg_host_model_i.byte_c({ADDR_HI, DEV_ID, 1'b0}, 1'b1, rx, a0);
      avg_host_model_i.byte_c(ofs, 1'b1, rx, a1);
      avg_host_model_i.byte_c(val, 1'b1, rx, a2);
      avg_host_model_i.stop_c();
      chk("write acks", 16'h0, {12'h0, sda_o, a0, a1, a2});
   endtask
   task automatic rd(input avg_byte_t ofs, output avg_byte_t val);
      logic a0, a1, a2, nack;
      avg_host_model_i.start_c();
      avg_host_model_i.byte_c({ADDR_HI, DEV_ID, 1'b0}, 1'b1, val, a0);
      avg_host_model_i.byte_c(ofs, 1'b1, val, a1);
      avg_host_model_i.start_c();
      avg_host_model_i.byte_c({ADDR_HI, DEV_ID, 1'b1}, 1'b1, val, a2);
      // host releases all data bits and ends with a nack
      avg_host_model_i.byte_c(8'hFF, 1'b1, val, nack);
      avg_host_model_i.stop_c();
      chk("read acks", 16'h0, {13'h0, a0, a1, a2});
   endtask
   task automatic rd_chk(input avg_byte_t ofs, input avg_byte_t e);
      avg_byte_t v;
      rd(ofs, v);
      chk("register read", {8'h0, e}, {8'h0, v});
   endtask
   // bounded wait for the ramp to reach its target
   task automatic settle();
      avg_host_model_i.wait_c(8);
      for (int n = 0; n < 20000 && busy !== 1'b0; n++) @(posedge clk);
      avg_host_model_i.wait_c(3);
   endtask
   task automatic chk_lvl(input logic [8:0] e, input logic ei);
      settle();
      chk("level", {7'h0, e}, {7'h0, level});
      chk("idle", {15'h0, ei}, {15'h0, idle});
   endtask
   // cycles between two consecutive level steps
   task automatic step_gap(input int e);
      logic [8:0] l0;
      int n;
      l0 = level;
      for (n = 0; n < 2000 && level === l0; n++) @(posedge clk);
      l0 = level;
      for (n = 0; n < 2000 && level === l0; n++) @(posedge clk);
      chk("step gap", e[15:0], n[15:0]);
   endtask
   task automatic t_reset();
      chk("reset level", 16'h19E, {7'h0, level}); // reset volume
      chk("reset gain", 16'h1, {14'h0, gain}); // gain default
      chk("reset pwm", 16'h10, {11'h0, pwm}); // rate default
      rd_chk(AVG_OFS_SLOT_CTRL, 8'h80); // slot reset
      rd_chk(AVG_OFS_VOLUME, 8'hCF); // volume reset
      rd_chk(AVG_OFS_ANALOG, 8'h55); // analog reset
      rd_chk(8'h05, 8'h00);
   endtask
   task automatic t_slot();
      wr(AVG_OFS_SLOT_CTRL, 8'hA5); // reserved bits kept
      rd_chk(AVG_OFS_SLOT_CTRL, 8'hA5); // readback
      src <= 1'b1;
      avg_host_model_i.wait_c(3);
      chk("slot field", 16'h5, {13'h0, slot}); // slot field used
      src <= 1'b0;
      avg_host_model_i.wait_c(8);
      chk("slot id", {13'h0, DEV_ID}, {13'h0, slot}); // id used
   endtask
   task automatic t_pwm();
      for (int c = 0; c < 8; c++) begin
         wr(AVG_OFS_ANALOG, {1'b0, c[2:0], c[1:0], 2'b01}); // reserved bits kept
         for (int s = 0; s < 2; s++) begin
            speed <= s[0];
            avg_host_model_i.wait_c(3);
            chk("pwm", {11'h0, PWM_TAB[c * 5 +: 5] >> s}, {11'h0, pwm}); // multiple
            chk("gain", {14'h0, c[1:0]}, {14'h0, gain}); // gain code
         end
         speed <= 1'b0;
      end
      rd_chk(AVG_OFS_ANALOG, 8'h7D); // readback
   endtask
   task automatic t_volume();
      wr(AVG_OFS_SLOT_CTRL, 8'hE5);
      vlsb <= 1'b1;
      wr(AVG_OFS_VOLUME, 8'h05);
      chk_lvl(9'h00B, 1'b0); // lsb joins
      vlsb <= 1'b0;
      wr(AVG_OFS_VOLUME, 8'h04);
      chk_lvl(9'h008, 1'b0); // lowest audible
      vlsb <= 1'b1;
      wr(AVG_OFS_VOLUME, 8'h03);
      chk_lvl(9'h000, 1'b1); // below acts as mute
   endtask
   task automatic t_mute();
      wr(AVG_OFS_SLOT_CTRL, 8'hA5);
      vlsb <= 1'b0;
      wr(AVG_OFS_VOLUME, 8'h04);
      step_gap(8 * LR_PER); // slow rate
      chk_lvl(9'h008, 1'b0); // slow ramp lands
      wr(AVG_OFS_SLOT_CTRL, 8'hF5);
      step_gap(LR_PER); // fast rate
      chk_lvl(9'h000, 1'b1); // mute ramps down
      wr(AVG_OFS_SLOT_CTRL, 8'hE5);
      chk_lvl(9'h008, 1'b0); // unmute restores
   endtask
   task automatic t_force();
      shut <= 1'b1;
      chk_lvl(9'h000, 1'b1); // shutdown ramps down
      shut <= 1'b0;
      chk_lvl(9'h008, 1'b0); // leaving shutdown ramps up
      sleep <= 1'b1;
      chk_lvl(9'h000, 1'b1); // sleep ramps down
      sleep <= 1'b0;
      chk_lvl(9'h008, 1'b0); // leaving sleep ramps up
   endtask
   // reset for 3 cycles, let synchronisers fill, then run every scenario
   initial begin
      repeat (3) @(posedge clk);
      rst <= 1'b0;
      repeat (6) @(posedge clk);
      t_reset();
      t_slot();
      t_pwm();
      t_volume();
      t_mute();
      t_force();
      end_sim();
   end
endmodule
`default_nettype wire
